// *** logic/gate_sync_counter_download.sv ***
`timescale 1ns/1ps

module byte_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = 16
) (
   // clock and reset
   input  wire logic         clk_i,
   input  wire logic         srst_i,
   // fill side
   input  wire logic         in_valid_i,
   input  wire logic [W-1:0] in_data_i,
   output logic              in_ready_o,
   // drain side
   output logic              out_valid_o,
   output logic [W-1:0]      out_data_o,
   input  wire logic         out_ready_i
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [AW:0]   cnt_reg;
   wire           wr_en;
   wire           rd_en;

   // head register keeps the drain side straight from a flop
   assign in_ready_o = (cnt_reg != (AW+1)'(DEPTH));
   assign wr_en      = in_valid_i & in_ready_o;
   assign rd_en      = (cnt_reg != '0) & (~out_valid_o | out_ready_i);

   always_ff @(posedge clk_i)
   begin
      if (wr_en)
         mem[wr_ptr_reg] <= in_data_i;
   end

   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         wr_ptr_reg  <= '0;
         rd_ptr_reg  <= '0;
         cnt_reg     <= '0;
         out_valid_o <= 1'b0;
         out_data_o  <= '0;
      end
      else
      begin
         if (wr_en)
            wr_ptr_reg <= wr_ptr_reg + AW'(1);
         if (rd_en)
         begin
            rd_ptr_reg <= rd_ptr_reg + AW'(1);
            out_data_o <= mem[rd_ptr_reg];
         end
         if (wr_en && !rd_en)
            cnt_reg <= cnt_reg + (AW+1)'(1);
         else if (rd_en && !wr_en)
            cnt_reg <= cnt_reg - (AW+1)'(1);
         if (rd_en)
            out_valid_o <= 1'b1;
         else if (out_ready_i)
            out_valid_o <= 1'b0;
      end
   end
endmodule : byte_fifo

module gate_sync_counter_download import download_pkg::*; #(
   parameter int CH_NUM     = 64,
   parameter int CNT_W      = 40,
   parameter int FIFO_DEPTH = 16
) (
   // clock and reset
   input  wire logic                       clk_i,
   input  wire logic                       srst_i,
   // pins
   input  wire logic [CH_NUM-1:0]          count_i,
   input  wire logic                       gate_i,
   // decoded command
   input  wire logic                       cmd_valid_i,
   input  wire cmd_type                    cmd_code_i,
   input  wire logic [$clog2(CH_NUM)-1:0]  cmd_first_i,
   input  wire logic [$clog2(CH_NUM)-1:0]  cmd_last_i,
   input  wire logic [1:0]                 cmd_timer_i,
   input  wire logic                       cmd_hex_i,
   output logic                            cmd_ready_o,
   // text stream
   output logic [7:0]                      tx_data_o,
   output logic                            tx_valid_o,
   input  wire logic                       tx_ready_i,
   // status
   output logic                            counting_o,
   output logic                            continuous_o
);
   localparam int CH_W = $clog2(CH_NUM);

   // digit helpers shared by the formatter
   function automatic logic [BCD_W-1:0] dd_adjust(input logic [BCD_W-1:0] b);
      logic [BCD_W-1:0] r;
      r = b;
      for (int i = 0; i < BCD_DIGITS; i++)
         if (r[4*i +: 4] > 4'h4)
            r[4*i +: 4] = r[4*i +: 4] + 4'h3;
      return r;
   endfunction : dd_adjust

   function automatic logic [3:0] sig_digits(input logic [BCD_W-1:0] b);
      logic [3:0] n;
      n = DEC_MIN_DIGITS;
      for (int i = int'(DEC_MIN_DIGITS); i < BCD_DIGITS; i++)
         if (b[4*i +: 4] != 4'h0)
            n = 4'(i + 1);
      return n;
   endfunction : sig_digits

   function automatic logic [7:0] to_char(input logic [3:0] nib);
      return (nib < 4'ha) ? (CHAR_ZERO + {4'h0, nib}) : (CHAR_HEX_OFF + {4'h0, nib});
   endfunction : to_char

   logic [CH_NUM-1:0] cnt_s1_reg, cnt_s2_reg, cnt_s3_reg;
   logic              gate_s1_reg, gate_s2_reg, gate_s3_reg;
   logic [DIV_W-1:0]  div_reg;
   logic [CNT_W-1:0]  cnt_reg  [CH_NUM];
   logic [CNT_W-1:0]  snap_cnt_reg [CH_NUM];
   logic [TIM_W-1:0]  timer_reg, snap_timer_reg;
   logic              run_reg, gated_reg, cont_reg;
   logic [CH_W-1:0]   cont_first_reg, cont_last_reg;
   logic              cont_tsel_reg, cont_hex_reg;
   logic [CH_W-1:0]   rec_last_reg;
   logic              rec_hex_reg, tpend_reg, first_item_reg;
   logic [CH_W:0]     ch_reg;
   state_type         state_reg, state_next;
   logic [VAL_W-1:0]  val_reg;
   logic [BCD_W-1:0]  bcd_reg;
   logic [5:0]        bit_cnt_reg;
   logic [3:0]        dig_reg, ndig_reg;
   logic              fifo_ready;

   // pins pass three flops; edges are taken between stages two and three
   always_ff @(posedge clk_i)
   begin
      cnt_s1_reg  <= count_i;
      cnt_s2_reg  <= cnt_s1_reg;
      cnt_s3_reg  <= cnt_s2_reg;
      gate_s1_reg <= gate_i;
      gate_s2_reg <= gate_s1_reg;
      gate_s3_reg <= gate_s2_reg;
   end

   // decode
   wire [CH_NUM-1:0] cnt_edge  = cnt_s2_reg & ~cnt_s3_reg;
   wire gate_rise  = gate_s2_reg & ~gate_s3_reg;
   wire gate_fall  = ~gate_s2_reg & gate_s3_reg;
   wire tick       = (div_reg == DIV_W'(TIMER_DIV - 1));
   wire count_en   = run_reg & (~gated_reg | gate_s2_reg);
   wire is_block   = (cmd_code_i == CMD_BLOCK_DEC) | (cmd_code_i == CMD_BLOCK_HEX);
   wire is_start   = (cmd_code_i == CMD_FREE_START) | (cmd_code_i == CMD_GATED_START);
   wire idle       = (state_reg == ST_IDLE);
   wire block_take = cmd_valid_i & is_block & idle;
   // gated records close each on-period; free records start at each rising gate
   wire gate_event = cont_reg & (gated_reg ? gate_fall : gate_rise);
   wire event_take = gate_event & idle & ~block_take;           // busy formatter drops event
   wire snap_take  = block_take | event_take;
   wire [CH_W-1:0] start_first = block_take ? cmd_first_i : cont_first_reg;
   wire [CH_W-1:0] start_last  = block_take ? cmd_last_i : cont_last_reg;
   wire start_tsel = block_take ? (cmd_timer_i == TIMER_SEL_ON) : cont_tsel_reg;
   wire start_hex  = block_take ? (cmd_code_i == CMD_BLOCK_HEX) : cont_hex_reg;
   wire more_items = tpend_reg | (ch_reg <= {1'b0, rec_last_reg});
   wire [BCD_W-1:0] bcd_shift = {bcd_reg[BCD_W-2:0], val_reg[VAL_W-1]};
   wire [BCD_W-1:0] bcd_adj   = dd_adjust(bcd_reg);              // digits after the add-3 pass
   wire [BCD_W-1:0] bcd_step  = {bcd_adj[BCD_W-2:0], val_reg[VAL_W-1]};
   wire [3:0] nib  = rec_hex_reg ? val_reg[4*dig_reg +: 4] : bcd_reg[4*dig_reg +: 4];
   wire wr_valid   = (state_reg == ST_EMIT) | (state_reg == ST_NEXT);
   wire [7:0] wr_data = (state_reg == ST_EMIT) ? to_char(nib) :
                        (more_items ? CHAR_SPACE : CHAR_CR);

   // timer tick divider
   always_ff @(posedge clk_i)
   begin
      if (srst_i || tick)
         div_reg <= '0;
      else
         div_reg <= div_reg + DIV_W'(1);
   end

   // counters and timer, with a whole-set snapshot on each record start
   always_ff @(posedge clk_i)
   begin
      for (int i = 0; i < CH_NUM; i++)
      begin
         if (srst_i)
            cnt_reg[i] <= '0;
         else if (count_en && cnt_edge[i])
            cnt_reg[i] <= cnt_reg[i] + CNT_W'(1);
         if (snap_take)
            snap_cnt_reg[i] <= cnt_reg[i];
      end
      if (srst_i)
         timer_reg <= TIMER_RESET;
      else if (count_en && tick)
         timer_reg <= timer_reg + TIM_W'(1);
      if (snap_take)
         snap_timer_reg <= timer_reg;
   end

   // run and continuous-mode control
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         run_reg        <= 1'b0;
         gated_reg      <= 1'b0;
         cont_reg       <= 1'b0;
         cont_first_reg <= '0;
         cont_last_reg  <= '0;
         cont_tsel_reg  <= 1'b0;
         cont_hex_reg   <= 1'b0;
      end
      else if (cmd_valid_i && is_start)
      begin
         run_reg        <= 1'b1;
         cont_reg       <= 1'b1;
         gated_reg      <= (cmd_code_i == CMD_GATED_START);
         cont_first_reg <= cmd_first_i;
         cont_last_reg  <= cmd_last_i;
         cont_tsel_reg  <= (cmd_timer_i == TIMER_SEL_ON);
         cont_hex_reg   <= cmd_hex_i;
      end
      else if (cmd_valid_i && cmd_code_i == CMD_CONT_STOP)
         cont_reg <= 1'b0;
      else if (cmd_valid_i && cmd_code_i == CMD_GEN_STOP)
      begin
         run_reg  <= 1'b0;
         cont_reg <= 1'b0;
      end
   end

   // formatter sequencing; a byte step waits for room in the fifo
   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         ST_IDLE: if (snap_take)
                     state_next = (start_tsel || start_first <= start_last) ? ST_LOAD : ST_NEXT;
         ST_LOAD: state_next = rec_hex_reg ? ST_EMIT : ST_CONV;
         ST_CONV: if (bit_cnt_reg == CONV_LAST_BIT)
                     state_next = ST_EMIT;
         ST_EMIT: if (fifo_ready && dig_reg == 4'h0)
                     state_next = ST_NEXT;
         ST_NEXT: if (fifo_ready)
                     state_next = more_items ? ST_LOAD : ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         state_reg      <= ST_IDLE;
         cmd_ready_o    <= 1'b0;
         rec_last_reg   <= '0;
         rec_hex_reg    <= 1'b0;
         tpend_reg      <= 1'b0;
         first_item_reg <= 1'b0;
         ch_reg         <= '0;
         val_reg        <= '0;
         bcd_reg        <= '0;
         bit_cnt_reg    <= '0;
         dig_reg        <= '0;
         ndig_reg       <= '0;
      end
      else
      begin
         state_reg   <= state_next;
         cmd_ready_o <= (state_next == ST_IDLE);
         unique case (state_reg)
            ST_IDLE: if (snap_take)
            begin
               ch_reg         <= {1'b0, start_first};
               rec_last_reg   <= start_last;
               rec_hex_reg    <= start_hex;
               tpend_reg      <= start_tsel;                   // timer leads the record
               first_item_reg <= 1'b1;
            end
            ST_LOAD:
            begin
               if (tpend_reg)
               begin
                  val_reg   <= snap_timer_reg;
                  tpend_reg <= 1'b0;
               end
               else
               begin
                  val_reg <= VAL_W'(snap_cnt_reg[ch_reg[CH_W-1:0]]);
                  ch_reg  <= ch_reg + (CH_W+1)'(1);
               end
               // hex widths are fixed, so the digit count is known now
               ndig_reg       <= first_item_reg ? HEX_FIRST_DIGITS : HEX_DIGITS;
               dig_reg        <= (first_item_reg ? HEX_FIRST_DIGITS : HEX_DIGITS) - 4'h1;
               first_item_reg <= 1'b0;
               bcd_reg        <= '0;
               bit_cnt_reg    <= '0;
            end
            ST_CONV:
            begin
               // serial shift-add-3, one bit per cycle to keep the adders small
               bcd_reg     <= (bit_cnt_reg == 6'h0) ? bcd_shift : bcd_step;
               val_reg     <= {val_reg[VAL_W-2:0], 1'b0};
               bit_cnt_reg <= bit_cnt_reg + 6'h1;
               if (bit_cnt_reg == CONV_LAST_BIT)
               begin
                  ndig_reg <= sig_digits(bcd_step);
                  dig_reg  <= sig_digits(bcd_step) - 4'h1;
               end
            end
            ST_EMIT: if (fifo_ready && dig_reg != 4'h0)
               dig_reg <= dig_reg - 4'h1;
            ST_NEXT: ;
         endcase
      end
   end

   // status outputs
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         counting_o   <= 1'b0;
         continuous_o <= 1'b0;
      end
      else
      begin
         counting_o   <= run_reg;
         continuous_o <= cont_reg;
      end
   end

   byte_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) tx_fifo (
      .clk_i       (clk_i),
      .srst_i      (srst_i),
      .in_valid_i  (wr_valid),
      .in_data_i   (wr_data),
      .in_ready_o  (fifo_ready),
      .out_valid_o (tx_valid_o),
      .out_data_o  (tx_data_o),
      .out_ready_i (tx_ready_i)
   );

   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i);

   sequence s_dec_conv;
      (state_reg == ST_CONV) [*8] ##40 (state_reg == ST_CONV) ##1 (state_reg == ST_EMIT);
   endsequence

   sequence s_record_start;
      (state_reg == ST_LOAD || state_reg == ST_NEXT) ##[0:50] wr_valid;
   endsequence

   snap_coherent_a: assert property (snap_take |=> snap_timer_reg == $past(timer_reg)
      && snap_cnt_reg[$past(start_first)] == $past(cnt_reg[start_first]))
      else $error("snapshot differs from live values");
   gated_hold_a: assert property (run_reg && gated_reg && !gate_s2_reg |=>
      timer_reg == $past(timer_reg))
      else $error("timer moved while gate off");
   free_count_a: assert property (run_reg && !gated_reg && tick |=>
      timer_reg == $past(timer_reg) + TIM_W'(1))
      else $error("timer missed a tick in free mode");
   gen_stop_a: assert property (cmd_valid_i && cmd_code_i == CMD_GEN_STOP |=>
      !run_reg && !cont_reg)
      else $error("general stop left counting or streaming on");
   cont_stop_a: assert property (cmd_valid_i && cmd_code_i == CMD_CONT_STOP |=>
      !cont_reg && run_reg == $past(run_reg))
      else $error("continuous stop misbehaved");
   hex_first_a: assert property (state_reg == ST_LOAD && rec_hex_reg && first_item_reg
      |=> ndig_reg == HEX_FIRST_DIGITS)
      else $error("first hex field not 12 digits");
   hex_rest_a: assert property (state_reg == ST_LOAD && rec_hex_reg && !first_item_reg
      |=> ndig_reg == HEX_DIGITS)
      else $error("later hex field not 10 digits");
   dec_min_a: assert property (state_reg == ST_EMIT && !rec_hex_reg |->
      ndig_reg >= DEC_MIN_DIGITS)
      else $error("decimal field under 10 digits");
   dec_conv_a: assert property (state_reg == ST_LOAD && !rec_hex_reg |=> s_dec_conv)
      else $error("decimal conversion length wrong");
   block_start_a: assert property (block_take |=> s_record_start)
      else $error("block download did not start a record");
endmodule : gate_sync_counter_download

// *** pkg/download_pkg.sv ***
package download_pkg;

   // command codes delivered by the front-end parser
   typedef enum logic [2:0] {
      CMD_NONE        = 3'b000,
      CMD_BLOCK_DEC   = 3'b001,
      CMD_BLOCK_HEX   = 3'b010,
      CMD_FREE_START  = 3'b011,
      CMD_GATED_START = 3'b100,
      CMD_CONT_STOP   = 3'b101,
      CMD_GEN_STOP    = 3'b110
   } cmd_type;

   // record formatter states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_LOAD = 3'b001,
      ST_CONV = 3'b010,
      ST_EMIT = 3'b011,
      ST_NEXT = 3'b100
   } state_type;

   // timing
   localparam int CLK_PERIOD_NS = 5;
   localparam int TIMER_TICK_NS = 100;
   localparam int TIMER_DIV     = (TIMER_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DIV_W         = $clog2(TIMER_DIV);

   // value and digit layout
   localparam int TIM_W      = 48;
   localparam int VAL_W      = 48;
   localparam int BCD_DIGITS = 15;
   localparam int BCD_W      = 4 * BCD_DIGITS;
   localparam logic [3:0] DEC_MIN_DIGITS   = 4'ha;
   localparam logic [3:0] HEX_FIRST_DIGITS = 4'hc;
   localparam logic [3:0] HEX_DIGITS       = 4'ha;
   localparam logic [5:0] CONV_LAST_BIT    = 6'h2f;

   // argument encodings
   localparam logic [1:0] TIMER_SEL_ON = 2'h1;

   // characters
   localparam logic [7:0] CHAR_ZERO    = 8'h30;
   localparam logic [7:0] CHAR_HEX_OFF = 8'h37;
   localparam logic [7:0] CHAR_SPACE   = 8'h20;
   localparam logic [7:0] CHAR_CR      = 8'h0d;

   // reset values
   localparam logic [TIM_W-1:0] TIMER_RESET = 48'h0;

endpackage : download_pkg

// *** tb/gate_sync_counter_download_tb.sv ***
`timescale 1ns/1ps
module gate_sync_counter_download_tb import download_pkg::*; ();
   logic        clk_i = 1'b0;
   logic        srst_i = 1'b1;
   logic [63:0] pins = 64'h0;
   logic        gate = 1'b0;
   logic        cmd_valid, cmd_ready, cmd_hex, tx_valid, tx_ready, counting, continuous;
   cmd_type     cmd_code;
   logic [5:0]  cmd_first, cmd_last;
   logic [1:0]  cmd_timer;
   logic [7:0]  tx_data;
   logic [7:0]  exp_q[$];
   logic [15:0] seed = 16'h0056;
   int          bad_count = 0;
   int          checked = 0;
   logic [47:0] a, b, c;

   always #2.5 clk_i = ~clk_i;

   gate_sync_counter_download #(.CH_NUM(64), .CNT_W(40), .FIFO_DEPTH(16)) i_dut (
      .clk_i(clk_i), .srst_i(srst_i), .count_i(pins), .gate_i(gate),
      .cmd_valid_i(cmd_valid), .cmd_code_i(cmd_code), .cmd_first_i(cmd_first),
      .cmd_last_i(cmd_last), .cmd_timer_i(cmd_timer), .cmd_hex_i(cmd_hex),
      .cmd_ready_o(cmd_ready), .tx_data_o(tx_data), .tx_valid_o(tx_valid),
      .tx_ready_i(tx_ready), .counting_o(counting), .continuous_o(continuous)
   );

   host_model i_host (
      .clk_i(clk_i), .srst_i(srst_i), .cmd_valid_o(cmd_valid), .cmd_code_o(cmd_code),
      .cmd_first_o(cmd_first), .cmd_last_o(cmd_last), .cmd_timer_o(cmd_timer),
      .cmd_hex_o(cmd_hex), .cmd_ready_i(cmd_ready), .tx_data_i(tx_data),
      .tx_valid_i(tx_valid), .tx_ready_o(tx_ready)
   );

   // xorshift from a fixed start, so every run draws the same values
   function automatic logic [15:0] rnd();
      seed = seed ^ (seed << 7);
      seed = seed ^ (seed >> 9);
      seed = seed ^ (seed << 8);
      return seed;
   endfunction : rnd

   // expected text of one field, space before all but the first
   function automatic void add_field(input logic [47:0] v, input int dig, input logic hex);
      logic [47:0] d;
      if (exp_q.size() != 0)
         exp_q.push_back(CHAR_SPACE);
      for (int i = dig - 1; i >= 0; i--)
      begin
         d = hex ? ((v >> (4 * i)) & 48'hf) : ((v / 48'(10 ** i)) % 48'ha);
         exp_q.push_back(d < 48'ha ? CHAR_ZERO + d[7:0] : CHAR_HEX_OFF + d[7:0]);
      end
   endfunction : add_field

   task automatic check(input logic [47:0] seen, input logic [47:0] exp);
      checked++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // wait for the whole record plus a margin for surplus bytes, then match it
   task automatic compare_rec(input int skip);
      int n;
      n = 0;
      exp_q.push_back(CHAR_CR);
      while (i_host.rx_q.size() < exp_q.size() && n < 8000)
      begin
         @(negedge clk_i);
         n++;
      end
      repeat (20) @(negedge clk_i);
      check(i_host.rx_q.size(), exp_q.size()); // record length
      while (exp_q.size() != 0 && i_host.rx_q.size() != 0)
      begin
         if (skip > 0)
            skip--;
         else
            check(i_host.rx_q[0], exp_q[0]); // field text
         void'(i_host.rx_q.pop_front());
         void'(exp_q.pop_front());
      end
      i_host.rx_q.delete();
      exp_q.delete();
   endtask : compare_rec

   // edges well apart so the three-flop synchroniser sees each one
   task automatic pulse(input int ch, input int n);
      repeat (n)
      begin
         pins[ch] = 1'b1;
         repeat (3) @(negedge clk_i);
         pins[ch] = 1'b0;
         repeat (3) @(negedge clk_i);
      end
   endtask : pulse

   task automatic gate_to(input logic v);
      gate = v;
      repeat (10) @(negedge clk_i);
   endtask : gate_to

   task automatic report_and_stop();
      $display("checks %0d, mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : report_and_stop

   // long enough for every test with the slow sink
   initial
   begin
      repeat (60000) @(posedge clk_i);
      bad_count++;
      report_and_stop();
   end

   initial
   begin
      repeat (20) @(negedge clk_i);
      srst_i = 1'b0;
      repeat (4) @(negedge clk_i);
      add_field(48'h0, 12, 1'b1);
      i_host.send(CMD_BLOCK_HEX, 6'h07, 6'h07, 2'h0, 1'b0);
      compare_rec(0); // single channel in hex
      $display("test empty hex done");
      a = 48'(rnd() % 7 + 1);
      b = 48'(rnd() % 7 + 1);
      i_host.send(CMD_FREE_START, 6'h03, 6'h04, 2'h0, 1'b1);
      pulse(3, int'(a));
      pulse(4, int'(b));
      i_host.send(CMD_CONT_STOP, 6'h00, 6'h00, 2'h0, 1'b0);
      repeat (3) @(negedge clk_i);
      check(continuous, 48'h0); // records off
      check(counting, 48'h1); // still counting
      pulse(3, 1);
      a = a + 1;
      repeat (10) @(negedge clk_i);
      add_field(a, 12, 1'b1);
      add_field(b, 10, 1'b1);
      i_host.send(CMD_BLOCK_HEX, 6'h03, 6'h04, 2'h0, 1'b0);
      compare_rec(0); // 12 then 10 digits
      add_field(a, 10, 1'b0);
      add_field(b, 10, 1'b0);
      i_host.send(CMD_BLOCK_DEC, 6'h03, 6'h04, 2'h0, 1'b0);
      check(cmd_ready, 48'h0); // busy while the record is formatted
      compare_rec(0); // ten decimal digits
      $display("test block range done");
      i_host.slow = 1'b1;
      i_host.send(CMD_FREE_START, 6'h03, 6'h03, 2'h0, 1'b1);
      gate_to(1'b1);
      add_field(a, 12, 1'b1);
      compare_rec(0); // record per rising gate edge
      gate_to(1'b0);
      pulse(3, 2);
      a = a + 2;
      gate_to(1'b1);
      add_field(a, 12, 1'b1);
      compare_rec(0); // second rising gate edge
      i_host.send(CMD_CONT_STOP, 6'h00, 6'h00, 2'h0, 1'b0);
      gate_to(1'b0);
      gate_to(1'b1);
      repeat (100) @(negedge clk_i);
      check(i_host.rx_q.size(), 0); // no record after stop
      i_host.send(CMD_FREE_START, 6'h03, 6'h03, 2'h0, 1'b1);
      i_host.send(CMD_GEN_STOP, 6'h00, 6'h00, 2'h0, 1'b0);
      repeat (3) @(negedge clk_i);
      check(counting, 48'h0); // halted
      check(continuous, 48'h0); // records off
      gate_to(1'b0);
      gate_to(1'b1);
      pulse(3, 3);
      repeat (100) @(negedge clk_i);
      check(i_host.rx_q.size(), 0); // no record after stop
      add_field(a, 12, 1'b1);
      i_host.send(CMD_BLOCK_HEX, 6'h03, 6'h03, 2'h0, 1'b0);
      compare_rec(0); // count frozen
      $display("test free run done");
      gate_to(1'b0);
      i_host.send(CMD_GATED_START, 6'h05, 6'h05, 2'h0, 1'b0);
      pulse(5, 2);
      c = 48'(rnd() % 7 + 1);
      gate_to(1'b1);
      pulse(5, int'(c));
      gate_to(1'b0);
      add_field(c, 10, 1'b0);
      compare_rec(0); // only gate-on counts, sent at gate
      i_host.send(CMD_GEN_STOP, 6'h00, 6'h00, 2'h0, 1'b0);
      $display("test gated done");
      add_field(48'h0, 12, 1'b1);
      add_field(48'h0, 10, 1'b1);
      i_host.send(CMD_BLOCK_HEX, 6'h00, 6'h00, 2'h1, 1'b0);
      compare_rec(12); // timer field first, then counter
      $display("test timer done");
      report_and_stop();
   end
endmodule : gate_sync_counter_download_tb

// *** tb/host_model.sv ***
`timescale 1ns/1ps
// host stand-in: issues decoded commands and drains the text stream
module host_model import download_pkg::*; (
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       srst_i,
   // command side
   output logic            cmd_valid_o,
   output cmd_type         cmd_code_o,
   output logic [5:0]      cmd_first_o,
   output logic [5:0]      cmd_last_o,
   output logic [1:0]      cmd_timer_o,
   output logic            cmd_hex_o,
   input  wire logic       cmd_ready_i,
   // text side
   input  wire logic [7:0] tx_data_i,
   input  wire logic       tx_valid_i,
   output logic            tx_ready_o
);
   logic [7:0]  rx_q[$];
   logic [15:0] stall_reg = 16'h0056;
   logic        slow = 1'b0;

   // idle values from time zero
   initial
   begin
      cmd_valid_o = 1'b0;
      cmd_code_o  = CMD_NONE;
      cmd_first_o = 6'h00;
      cmd_last_o  = 6'h00;
      cmd_timer_o = 2'h0;
      cmd_hex_o   = 1'b0;
      tx_ready_o  = 1'b0;
   end

   // slow mode stalls three cycles in four so the fifo fills up
   always @(negedge clk_i)
   begin
      stall_reg = stall_reg ^ (stall_reg << 7);
      stall_reg = stall_reg ^ (stall_reg >> 9);
      stall_reg = stall_reg ^ (stall_reg << 8);
      tx_ready_o <= slow ? &stall_reg[1:0] : |stall_reg[1:0];
   end

   // collect every byte handed over
   always @(posedge clk_i)
      if (!srst_i && tx_valid_i && tx_ready_o)
         rx_q.push_back(tx_data_i);

   // one command held across one rising edge, only once the block is idle
   task automatic send(input cmd_type code, input logic [5:0] first,
                       input logic [5:0] last, input logic [1:0] tmr, input logic hex);
      int n;
      n = 0;
      while (!cmd_ready_i && n < 8000)
      begin
         @(negedge clk_i);
         n++;
      end
      @(negedge clk_i);
      cmd_valid_o = 1'b1;
      cmd_code_o  = code;
      cmd_first_o = first; // channel range first..last
      cmd_last_o  = last;
      cmd_timer_o = tmr; // 00 drops the timer, 01 includes it
      cmd_hex_o   = hex;
      @(negedge clk_i);
      cmd_valid_o = 1'b0;
   endtask : send
endmodule : host_model
